/* verilog/boot_prot_defines.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the boot flash protection block.
// Assumes: APB word addressing, 25 MHz pclk.
// Notes:   Definitions only; included by bare name.
`ifndef BOOT_PROT_DEFINES_SVH
`define BOOT_PROT_DEFINES_SVH

// ==========================================================================
// Register map
// ==========================================================================
`define OFS_STORE_PROGRAM_CONTROL 8'h00
`define OFS_LOCK_STATUS           8'h04

// ==========================================================================
// Control register fields
// ==========================================================================
`define BIT_READY_IRQ_ENABLE  7
`define BIT_RWW_BUSY          6
`define BIT_RESERVED          5
`define CMD_HI                4
`define CMD_REENABLE          5'h11
`define CMD_LOCK_SET          5'h09
`define CMD_PAGE_WRITE        5'h05
`define CMD_PAGE_ERASE        5'h03
`define CMD_BUFFER_LOAD       5'h01

// ==========================================================================
// Lock fields and fuse, 1 means unprogrammed
// ==========================================================================
`define LOCK_UNPROGRAMMED     2'h3
`define LOCKS_UNPROGRAMMED    4'hf
`define FUSE_UNPROGRAMMED     1'b1
`define APP_RESET_ADDR        13'h0000
`define ADDR_W                13

// ==========================================================================
// Timing
// ==========================================================================
`define CLK_PERIOD_NS         40
`define ARM_WINDOW_NS         160
`define ARM_CYCLES            (`ARM_WINDOW_NS / `CLK_PERIOD_NS)

`endif

/* verilog/boot_prot_pkg.sv */
// Purpose: Types shared by the boot flash protection block.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   Numbers live in the defines header.
package boot_prot_pkg;

   // ==========================================================================
   // Sequencer states and decoded commands
   // ==========================================================================
   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_BUSY} state_type;
   typedef enum logic [2:0] {CMD_NONE, CMD_LOAD, CMD_ERASE, CMD_WRITE, CMD_LOCK, CMD_REEN} cmd_type;

endpackage : boot_prot_pkg

/* verilog/arm_window.sv */
// Purpose: Counts the arming window of the store-enable bit.
// Assumes: Start and consume come from the same clock domain.
// Notes:   Expired pulses on the last armed cycle when nothing consumed the window.
`timescale 1ns/1ps
`include "boot_prot_defines.svh"

module arm_window (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic start,
   input  wire logic consume,
   output logic      expired
);

   // ==========================================================================
   // Down counter
   // ==========================================================================
   logic [2:0] count_r;   // Cycles of the window still open.
   logic [2:0] count_nxt; // Next count.

   // A new start reloads; a consume closes the window at once.
   assign count_nxt = start ? 3'(`ARM_CYCLES) :
                      (consume || count_r == 3'h0) ? 3'h0 : count_r - 3'h1;
   assign expired   = (count_r == 3'h1) && !consume && !start;

   // The counter holds the window open for exactly the armed cycles.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         count_r <= 3'h0;
      else
         count_r <= count_nxt;
   end

endmodule : arm_window

/* verilog/lock_fuse_store.sv */
// Purpose: Holds the boot lock fields and the reset-vector fuse.
// Assumes: Reset models the erased state of a fresh part.
// Notes:   The CPU may only program lock bits; only chip erase unprograms them.
`timescale 1ns/1ps
`include "boot_prot_defines.svh"

module lock_fuse_store (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       cpu_lock_set,
   input  wire logic [3:0] cpu_lock_data,
   input  wire logic       prog_lock_write,
   input  wire logic [3:0] prog_lock_data,
   input  wire logic       prog_fuse_write,
   input  wire logic       prog_fuse_data,
   input  wire logic       prog_chip_erase,
   output logic [3:0]      locks,
   output logic            reset_vector_select_fuse
);

   // ==========================================================================
   // Storage
   // ==========================================================================
   logic [3:0] locks_r;  // {boot_lock_hi, boot_lock_lo, app_lock_hi, app_lock_lo}.
   logic [3:0] locks_nxt;
   logic       fuse_r;   // Reset-vector select fuse.
   logic       fuse_nxt;

   // Programming only drives bits toward zero, so a set can never unlock.
   assign locks_nxt = prog_chip_erase ? `LOCKS_UNPROGRAMMED :
                      prog_lock_write ? (locks_r & prog_lock_data) :
                      cpu_lock_set    ? (locks_r & cpu_lock_data) : locks_r;
   // The fuse has no CPU path at all.
   assign fuse_nxt  = prog_fuse_write ? prog_fuse_data : fuse_r;

   // Storage update.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         locks_r <= `LOCKS_UNPROGRAMMED;
         fuse_r  <= `FUSE_UNPROGRAMMED;
      end
      else
      begin
         locks_r <= locks_nxt;
         fuse_r  <= fuse_nxt;
      end
   end

   assign locks                    = locks_r;
   assign reset_vector_select_fuse = fuse_r;

endmodule : lock_fuse_store

/* verilog/boot_flash_protection_ctrl.sv */
// Purpose: Self-programming access control for on-chip program flash.
// Assumes: CPU strobes arrive on pclk; flash_done pulses at the end of erase or write.
// Notes:   APB slave with zero wait states; control word at 0x00, lock view at 0x04.
`timescale 1ns/1ps
`include "boot_prot_defines.svh"

module boot_flash_protection_ctrl (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               store_strobe,
   input  wire logic               store_target_boot,
   input  wire logic               store_target_rww,
   input  wire logic               exec_from_boot,
   input  wire logic [3:0]         lock_set_data,
   input  wire logic               load_target_boot,
   input  wire logic               load_target_rww,
   output logic                    load_allowed,
   input  wire logic               vectors_in_boot,
   input  wire logic               global_irq_flag,
   output logic                    irq_block,
   output logic                    ready_irq,
   output logic                    flash_start,
   output logic                    flash_erase,
   input  wire logic               flash_done,
   output logic                    buffer_load,
   output logic                    buffer_discard,
   output logic                    cpu_halt,
   input  wire logic [`ADDR_W-1:0] boot_reset_addr,
   output logic [`ADDR_W-1:0]      reset_vector,
   input  wire logic               prog_lock_write,
   input  wire logic [3:0]         prog_lock_data,
   input  wire logic               prog_fuse_write,
   input  wire logic               prog_fuse_data,
   input  wire logic               prog_chip_erase
);

   // ==========================================================================
   // Helper functions
   // ==========================================================================

   // Maps the low five control bits to a command; anything else is no command.
   function automatic boot_prot_pkg::cmd_type decode_cmd(input logic [4:0] bits);
      boot_prot_pkg::cmd_type c;
      c = boot_prot_pkg::CMD_NONE;
      unique case (bits)
         `CMD_REENABLE:    c = boot_prot_pkg::CMD_REEN;
         `CMD_LOCK_SET:    c = boot_prot_pkg::CMD_LOCK;
         `CMD_PAGE_WRITE:  c = boot_prot_pkg::CMD_WRITE;
         `CMD_PAGE_ERASE:  c = boot_prot_pkg::CMD_ERASE;
         `CMD_BUFFER_LOAD: c = boot_prot_pkg::CMD_LOAD;
         default:          c = boot_prot_pkg::CMD_NONE;
      endcase
      return c;
   endfunction : decode_cmd

   // A lock field blocks stores when its low bit is programmed (10 or 00).
   function automatic logic blocks_store(input logic [1:0] lock);
      return !lock[0];
   endfunction : blocks_store

   // A lock field blocks cross-section loads when its high bit is programmed (00 or 01).
   function automatic logic blocks_load(input logic [1:0] lock);
      return !lock[1];
   endfunction : blocks_load

   // ==========================================================================
   // State
   // ==========================================================================
   boot_prot_pkg::state_type state_r;         // Store sequencer state.
   boot_prot_pkg::state_type state_nxt;       // Next state.
   boot_prot_pkg::cmd_type   cmd_r;           // Command armed by the last control write.
   boot_prot_pkg::cmd_type   cmd_nxt;         // Next armed command.
   logic                     irq_en_r;        // Ready interrupt enable.
   logic                     rww_busy_r;      // Read-while-write section busy.
   logic                     rww_busy_nxt;    // Next busy value.
   logic                     halt_r;          // CPU halted for a no-read-while-write op.
   logic                     halt_nxt;        // Next halt value.
   logic                     flash_start_r;   // Start pulse to the flash macro.
   logic                     flash_erase_r;   // Kind of the operation: erase when high.
   logic                     buffer_load_r;   // Word load pulse to the page buffer.
   logic                     discard_r;       // Page buffer discard pulse.
   logic [31:0]              prdata_r;        // Registered read data.
   logic                     pslverr_r;       // Registered error answer.
   logic [`ADDR_W-1:0]       reset_vector_r;  // Reset vector caught after reset release.
   logic [3:0]               locks;           // Lock fields from the store.
   logic                     fuse;            // Reset-vector select fuse.
   logic                     expired;         // Arming window ran out.

   // ==========================================================================
   // Bus decode
   // ==========================================================================
   wire                      setup_phase = psel && !penable;
   wire                      ctl_hit     = (paddr == `OFS_STORE_PROGRAM_CONTROL);
   wire                      lock_hit    = (paddr == `OFS_LOCK_STATUS);
   wire                      bus_write   = psel && penable && pwrite;
   wire                      ctl_write   = bus_write && ctl_hit;
   wire [1:0]                app_lock    = locks[1:0];
   wire [1:0]                boot_lock   = locks[3:2];
   wire                      op_enable   = (state_r != boot_prot_pkg::ST_IDLE);
   wire boot_prot_pkg::cmd_type wr_cmd   = decode_cmd(pwdata[`CMD_HI:0]);

   // A store is only meaningful from the boot section while a command is armed.
   wire                      store_take  = store_strobe && exec_from_boot &&
                                           (state_r == boot_prot_pkg::ST_ARMED);
   // General lock levels are deliberately not consulted here.
   wire                      store_lock  = store_target_boot ? blocks_store(boot_lock)
                                                             : blocks_store(app_lock);
   wire                      is_prog     = (cmd_r == boot_prot_pkg::CMD_ERASE) ||
                                           (cmd_r == boot_prot_pkg::CMD_WRITE);
   // Blocked programming simply drops back to idle, leaving flash and flags alone.
   wire                      prog_go     = store_take && is_prog && !store_lock;

   // Arming happens only from idle, so a re-enable during an operation is lost.
   wire                      arm         = ctl_write && !op_enable &&
                                           (wr_cmd != boot_prot_pkg::CMD_NONE);

   // ==========================================================================
   // Sub-blocks
   // ==========================================================================
   arm_window u_arm_window (
      .pclk    (pclk),
      .presetn (presetn),
      .start   (arm),
      .consume (store_take),
      .expired (expired)
   );

   // Lock set by a store ANDs in the data; only chip erase restores ones.
   lock_fuse_store u_lock_fuse_store (
      .pclk                     (pclk),
      .presetn                  (presetn),
      .cpu_lock_set             (store_take && cmd_r == boot_prot_pkg::CMD_LOCK),
      .cpu_lock_data            (lock_set_data),
      .prog_lock_write          (prog_lock_write),
      .prog_lock_data           (prog_lock_data),
      .prog_fuse_write          (prog_fuse_write),
      .prog_fuse_data           (prog_fuse_data),
      .prog_chip_erase          (prog_chip_erase),
      .locks                    (locks),
      .reset_vector_select_fuse (fuse)
   );

   // ==========================================================================
   // Sequencer
   // ==========================================================================

   // Idle until armed; armed for the window; busy from start until flash_done.
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         boot_prot_pkg::ST_IDLE:
            if (arm)
               state_nxt = boot_prot_pkg::ST_ARMED;
         boot_prot_pkg::ST_ARMED:
            if (prog_go)
               state_nxt = boot_prot_pkg::ST_BUSY;
            else if (store_take || expired)
               state_nxt = boot_prot_pkg::ST_IDLE;
         boot_prot_pkg::ST_BUSY:
            if (flash_done)
               state_nxt = boot_prot_pkg::ST_IDLE;
      endcase
   end

   assign cmd_nxt = arm ? wr_cmd : cmd_r;

   // Busy rises with an accepted op on the rww section and falls on re-enable or a load.
   assign rww_busy_nxt = (prog_go && store_target_rww) ? 1'b1 :
                         (store_take && (cmd_r == boot_prot_pkg::CMD_REEN ||
                                         cmd_r == boot_prot_pkg::CMD_LOAD)) ? 1'b0 : rww_busy_r;

   // Programming the no-read-while-write section stalls the core for the whole operation.
   assign halt_nxt = (prog_go && !store_target_rww) ? 1'b1 :
                     (state_r == boot_prot_pkg::ST_BUSY && flash_done) ? 1'b0 : halt_r;

   // Sequencer registers.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_r    <= boot_prot_pkg::ST_IDLE;
         cmd_r      <= boot_prot_pkg::CMD_NONE;
         rww_busy_r <= 1'b0;
         halt_r     <= 1'b0;
      end
      else
      begin
         state_r    <= state_nxt;
         cmd_r      <= cmd_nxt;
         rww_busy_r <= rww_busy_nxt;
         halt_r     <= halt_nxt;
      end
   end

   // Strobes toward the flash and the page buffer.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flash_start_r <= 1'b0;
         flash_erase_r <= 1'b0;
         buffer_load_r <= 1'b0;
         discard_r     <= 1'b0;
      end
      else
      begin
         flash_start_r <= prog_go;
         if (prog_go)
            flash_erase_r <= (cmd_r == boot_prot_pkg::CMD_ERASE);
         buffer_load_r <= store_take && (cmd_r == boot_prot_pkg::CMD_LOAD);
         // Writing the re-enable bit throws away a partly loaded page at once.
         discard_r     <= ctl_write && pwdata[`CMD_HI];
      end
   end

   // ==========================================================================
   // Register file
   // ==========================================================================

   // The enable bit may change even while an operation runs.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_en_r <= 1'b0;
      else if (ctl_write)
         irq_en_r <= pwdata[`BIT_READY_IRQ_ENABLE];
   end

   // Read data is built in the setup phase so it is stable for the access phase.
   // Bit 5 of the control word is never driven, so it always reads zero.
   wire [31:0] ctl_view  = {24'h00_0000, irq_en_r, rww_busy_r, 1'b0, 4'h0, op_enable};
   wire [31:0] lock_view = {26'h000_0000, halt_r, fuse, locks};
   wire        hit       = ctl_hit || lock_hit;

   // Bus answer registers; unmapped addresses answer with an error and zero data.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end
      else if (setup_phase)
      begin
         prdata_r  <= (pwrite || !hit) ? 32'h0000_0000 : (ctl_hit ? ctl_view : lock_view);
         pslverr_r <= !hit;
      end
   end

   // Reset vector follows the fuse; it is caught after release, not under reset.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         reset_vector_r <= `APP_RESET_ADDR;
      else
         reset_vector_r <= fuse ? `APP_RESET_ADDR : boot_reset_addr;
   end

   // ==========================================================================
   // Outputs
   // ==========================================================================
   assign prdata         = prdata_r;
   assign pready         = 1'b1;
   assign pslverr        = pslverr_r && psel && penable;
   assign flash_start    = flash_start_r;
   assign flash_erase    = flash_erase_r;
   assign buffer_load    = buffer_load_r;
   assign buffer_discard = discard_r;
   assign cpu_halt       = halt_r;
   assign reset_vector   = reset_vector_r;
   // Ready interrupt holds while the enable bit and the global interrupt flag are set and the store-enable bit is clear.
   assign ready_irq      = irq_en_r && global_irq_flag && !op_enable;
   // Cross-section loads per the high lock bits, and nothing from a busy rww section.
   assign load_allowed   = !(load_target_rww && rww_busy_r) &&
                           !(!load_target_boot && exec_from_boot && blocks_load(app_lock)) &&
                           !(load_target_boot && !exec_from_boot && blocks_load(boot_lock));
   // Vectors living in the other section would cross a load lock, so mask them.
   assign irq_block      = (blocks_load(app_lock) && vectors_in_boot && !exec_from_boot) ||
                           (blocks_load(boot_lock) && !vectors_in_boot && exec_from_boot);

   // ==========================================================================
   // Assertions
   // ==========================================================================
   sequence armed_quiet;
      (state_r == boot_prot_pkg::ST_ARMED && !store_strobe) [*4];
   endsequence

   a_window_expiry: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(state_r == boot_prot_pkg::ST_ARMED) ##0 armed_quiet |=> state_r == boot_prot_pkg::ST_IDLE)
      else $error("Arming window did not close after four cycles.");

   a_bad_cmd_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      ctl_write && state_r == boot_prot_pkg::ST_IDLE && wr_cmd == boot_prot_pkg::CMD_NONE
      |=> state_r == boot_prot_pkg::ST_IDLE)
      else $error("Undefined command armed the sequencer.");

   a_reserved_zero: assert property (@(posedge pclk) disable iff (!presetn)
      psel && penable && !pwrite && ctl_hit |-> prdata[`BIT_RESERVED] == 1'b0)
      else $error("Reserved control bit read as one.");

   a_store_blocked: assert property (@(posedge pclk) disable iff (!presetn)
      store_take && is_prog && store_lock |=> !flash_start && !op_enable && $stable(rww_busy_r))
      else $error("Locked store reached the flash.");

   a_busy_holds: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == boot_prot_pkg::ST_BUSY && !flash_done |=> state_r == boot_prot_pkg::ST_BUSY)
      else $error("Operation left busy without completion.");

   a_rww_busy_set: assert property (@(posedge pclk) disable iff (!presetn)
      prog_go && store_target_rww |=> rww_busy_r && !cpu_halt ##1 !load_allowed || !load_target_rww)
      else $error("Busy flag not raised for rww operation.");

   a_ready_irq: assert property (@(posedge pclk) disable iff (!presetn)
      state_r == boot_prot_pkg::ST_BUSY && flash_done && irq_en_r && !ctl_write
      |=> ready_irq == global_irq_flag)
      else $error("Ready interrupt missing after operation end.");

   a_fuse_cpu_proof: assert property (@(posedge pclk) disable iff (!presetn)
      !prog_fuse_write |=> $stable(fuse))
      else $error("Fuse changed without programming interface.");

endmodule : boot_flash_protection_ctrl

/* verif/cpu_flash_model.sv */
// Purpose: Far side model: the flash array answering each started operation.
// Assumes: flash_start is a one-cycle pulse.
// Notes:   Done comes a fixed number of cycles later.
`timescale 1ns/1ps
module cpu_flash_model #(parameter int OP_CYCLES = 6) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic flash_start,
   output logic      flash_done
);
   int cnt;
   // ==========
   // Counts a started operation down, then pulses done for one cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn) begin cnt <= 0; flash_done <= 1'b0; end
      else begin
         flash_done <= (cnt == 1);
         cnt <= flash_start ? OP_CYCLES : (cnt > 0 ? cnt - 1 : 0);
      end
   end
endmodule : cpu_flash_model

/* verif/boot_flash_protection_ctrl_test.sv */
// Purpose: Self-checking bench of the boot flash protection block.
// Assumes: Zero wait APB, control at 0x00, lock view at 0x04.
// Notes:   Inputs change by non-blocking assignment after rising edges.
`timescale 1ns/1ps
module boot_flash_protection_ctrl_test;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready, strb = 0, read_while_write_section = 0, boot = 1;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic ld_boot = 0, vib = 0, gie = 1, irq_block, ready_irq, load_allowed, cpu_halt, fstart, fdone;
   logic plw = 0, pfw = 0, pce = 0;
   logic tgt = 1, ld_rww = 0, erase, bload, disc;
   logic [3:0] lsd = 4'hf, fs; // Store data for lock set; flash strobes caught after each store.
   logic [3:0] pld = 4'hf;
   logic [12:0] rv;
   int n_fail = 0, comparisons = 0, i;
   always #20 pclk = ~pclk;
   boot_flash_protection_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .store_strobe(strb), .store_target_boot(tgt), .store_target_rww(read_while_write_section), .exec_from_boot(boot),
      .lock_set_data(lsd), .load_target_boot(ld_boot), .load_target_rww(ld_rww), .load_allowed(load_allowed),
      .vectors_in_boot(vib), .global_irq_flag(gie), .irq_block(irq_block), .ready_irq(ready_irq),
      .flash_start(fstart), .flash_erase(erase), .flash_done(fdone), .buffer_load(bload), .buffer_discard(disc),
      .cpu_halt(cpu_halt), .boot_reset_addr(13'h1c00), .reset_vector(rv), .prog_lock_write(plw),
      .prog_lock_data(pld), .prog_fuse_write(pfw), .prog_fuse_data(1'b0), .prog_chip_erase(pce));
   // A long operation leaves room to poke the block while it is still busy.
   cpu_flash_model #(.OP_CYCLES(20)) FM (.pclk(pclk), .presetn(presetn), .flash_start(fstart), .flash_done(fdone));
   task chk(input string n, input logic [31:0] e, input logic [31:0] s);
      comparisons++;
      if (s !== e) begin $display("ERROR %s expected %h seen %h", n, e, s); n_fail++; end
   endtask : chk
   task finish_test;
      if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test
   // APB transfer; held until pready is seen at a rising edge.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk); psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk); penable <= 1;
      i = 0;
      do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 50);
      r = prdata;
      psel <= 0; penable <= 0;
      if (i >= 50) begin n_fail++; finish_test; end
   endtask : apb
   task store;
      @(posedge pclk); strb <= 1;
      @(posedge pclk); strb <= 0;
      #1 fs = {fstart, erase, bload, disc};
      @(posedge pclk); #1;
   endtask : store
   task wait_idle;
      i = 0;
      do begin apb(0, 8'h00, 0); i++; end while (r[0] !== 1'b0 && i < 30);
      if (i >= 30) begin n_fail++; finish_test; end
   endtask : wait_idle
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1;
      apb(0, 8'h00, 0); chk("ctrl_reset", 32'h0000_0000, r);
      apb(0, 8'h04, 0); chk("locks_reset", 32'h0000_001f, r);
      apb(0, 8'h08, 0); chk("unmapped", 32'h0000_0001, {31'h0, pslverr});
      read_while_write_section <= 1; tgt <= 0; ld_rww <= 1; apb(1, 8'h00, 32'h0000_0083); store;
      chk("erase_start", 4'hc, fs);
      apb(1, 8'h00, 32'h0000_0091); #1 chk("discard", 1, disc);
      store; chk("reen_busy", 4'h4, fs);
      apb(0, 8'h00, 0); chk("busy_set", 32'h0000_00c1, r);
      chk("rww_load", 0, load_allowed);
      wait_idle; chk("done", 32'h0000_00c0, r);
      chk("ready_irq", 1, ready_irq);
      apb(1, 8'h00, 32'h0000_0091); store; wait_idle;
      chk("reenable", 32'h0000_0080, r);
      apb(1, 8'h00, 32'h0000_0005); store; chk("write_start", 4'h8, fs);
      wait_idle; chk("write_done", 32'h0000_0040, r);
      apb(1, 8'h00, 32'h0000_0001); store; chk("load", 4'h2, fs);
      apb(0, 8'h00, 0); chk("load_clear", 32'h0000_0000, r);
      apb(1, 8'h00, 32'h0000_0001); apb(0, 8'h00, 0); chk("armed", 32'h0000_0001, r);
      apb(0, 8'h00, 0); chk("expired", 32'h0000_0000, r);
      store; chk("stale_store", 4'h0, fs);
      apb(1, 8'h00, 32'h0000_0007); apb(0, 8'h00, 0); chk("bad_cmd", 32'h0000_0000, r);
      read_while_write_section <= 0; apb(1, 8'h00, 32'h0000_0003); store;
      chk("halt", 1, cpu_halt);
      wait_idle; chk("halt_end", 0, cpu_halt);
      @(posedge pclk); plw <= 1; pld <= 4'he; @(posedge pclk); plw <= 0;
      apb(0, 8'h04, 0); chk("app_lock", 32'h0000_001e, r);
      apb(1, 8'h00, 32'h0000_0003); store; chk("app_store", 4'h4, fs);
      apb(0, 8'h00, 0); chk("app_state", 32'h0000_0000, r);
      chk("load_app_free", 1, load_allowed);
      lsd <= 4'hc; apb(1, 8'h00, 32'h0000_0009); store;
      apb(0, 8'h04, 0); chk("cpu_lock", 32'h0000_001c, r);
      chk("load_app", 0, load_allowed);
      boot <= 0; vib <= 1; @(posedge pclk); #1;
      chk("irq_mask", 1, irq_block);
      @(posedge pclk); pce <= 1; pfw <= 1; @(posedge pclk); pce <= 0; pfw <= 0;
      apb(0, 8'h04, 0); chk("erased", 32'h0000_000f, r);
      chk("vector", 13'h1c00, rv);
      @(posedge pclk); plw <= 1; pld <= 4'h3; ld_boot <= 1; @(posedge pclk); plw <= 0;
      #1 chk("load_boot", 0, load_allowed);
      @(posedge pclk); boot <= 1; vib <= 0; tgt <= 1; #1 chk("irq_boot", 1, irq_block);
      apb(1, 8'h00, 32'h0000_0003); store; chk("boot_store", 4'h4, fs);
      finish_test;
   end
endmodule : boot_flash_protection_ctrl_test
